// file: core/root_hub_port_status.sv
// Root hub port reset, suspend and overcurrent status for the downstream ports
//
// Overview of operation
// [RL1] Reset status reads 1 during reset signaling
// [RL2] Writing 1 to reset bit starts reset
// [RL3] Reset on detached port flags connect change
// [RL4] Overcurrent bit meaningful only in per-port mode
// [RL5] Overcurrent bit reads 0 without per-port mode
// [RL6] Overcurrent bit follows the port's overcurrent condition
// [RL7] Suspend status reads 1 while suspended or resuming
// [RL8] Suspend set by write, cleared ending resume
// [RL9] Suspend never set while port detached
// [RL10] Suspend cleared at reset end, controller resume; the code clears it when reset starts
// [RL11] Upstream resume from suspended port reaches controller
// [RL12] Writing 1 to suspend bit suspends port
// [RL13] Suspend on detached port flags connect change
// [RL14] Reset status clears as reset change sets
// [RL15] Attached bit reports device presence on port
// [RL16] Each port keeps its own status state
module root_hub_port_status
    import rh_port_pkg::*;
#(
    parameter int RESET_CYCLES = PORT_RESET_CYCLES,
    parameter int RESUME_LEN_CYCLES = RESUME_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Port conditions
    input wire logic [NUM_PORTS-1:0] device_attached,
    input wire logic [NUM_PORTS-1:0] overcurrent_in,
    input wire logic [NUM_PORTS-1:0] upstream_resume,
    // Controller side
    input wire logic controller_resume_state,
    input wire logic per_port_oc_mode,
    // Port control
    output logic [NUM_PORTS-1:0] port_reset_active,
    output logic [NUM_PORTS-1:0] port_suspended,
    output logic [NUM_PORTS-1:0] resume_to_controller
);

    localparam logic [COUNT_W-1:0] RESET_LOAD = COUNT_W'(RESET_CYCLES - 1);
    localparam logic [COUNT_W-1:0] RESUME_LOAD = COUNT_W'(RESUME_LEN_CYCLES - 1);

    hub_s st_r;
    hub_s st_nxt;
    logic [NUM_PORTS-1:0][31:0] status_word;
    logic [NUM_PORTS-1:0] write_hit;
    logic [NUM_PORTS-1:0] set_reset;
    logic [NUM_PORTS-1:0] set_suspend;

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    port_reg_access u_reg (
        .clock(clock),
        .srst(srst),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .status_word(status_word),
        .write_hit(write_hit)
    );

    function automatic logic is_suspended(input port_phase_e ph);
        is_suspended = (ph == PH_SUSPENDED) || (ph == PH_RESUMING);
    endfunction

    // ----------------------------------------
    // Status words
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            status_word[i] = '0;
            status_word[i][BIT_ATTACHED] = device_attached[i]; // [RL15]
            status_word[i][BIT_RESET] = (st_r.ports[i].phase == PH_RESETTING); // [RL1]
            status_word[i][BIT_SUSPEND] = is_suspended(st_r.ports[i].phase); // [RL7]
            status_word[i][BIT_OVERCURRENT] = st_r.ports[i].oc_flag;
            status_word[i][BIT_CONNECT_CHG] = st_r.ports[i].connect_chg;
            status_word[i][BIT_SUSPEND_CHG] = st_r.ports[i].suspend_chg;
            status_word[i][BIT_RESET_CHG] = st_r.ports[i].reset_chg;
        end
    end

    // ----------------------------------------
    // Port state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < NUM_PORTS; i++) begin
            // Only a written 1 acts; zeros are ignored
            set_reset[i] = write_hit[i] && reg_wdata[BIT_RESET]; // [RL2]
            set_suspend[i] = write_hit[i] && reg_wdata[BIT_SUSPEND]; // [RL12]
            st_nxt.ports[i].resume_pulse = 1'b0;
            // Qualified by the mode so a stray sensor reads 0 when unsupported
            st_nxt.ports[i].oc_flag = per_port_oc_mode && overcurrent_in[i]; // [RL4] [RL5] [RL6]
            // Change flags clear first so any set below wins
            if (write_hit[i] && reg_wdata[BIT_CONNECT_CHG]) begin
                st_nxt.ports[i].connect_chg = 1'b0;
            end
            if (write_hit[i] && reg_wdata[BIT_SUSPEND_CHG]) begin
                st_nxt.ports[i].suspend_chg = 1'b0;
            end
            if (write_hit[i] && reg_wdata[BIT_RESET_CHG]) begin
                st_nxt.ports[i].reset_chg = 1'b0;
            end
            case (st_r.ports[i].phase)
                PH_RESETTING: begin
                    if (st_r.ports[i].count == COUNT_ZERO) begin
                        st_nxt.ports[i].phase = PH_IDLE; // [RL14] [RL10]
                        st_nxt.ports[i].reset_chg = 1'b1; // [RL14]
                    end else begin
                        st_nxt.ports[i].count = st_r.ports[i].count - COUNT_ONE;
                    end
                end
                PH_SUSPENDED: begin
                    if (upstream_resume[i]) begin
                        st_nxt.ports[i].phase = PH_RESUMING;
                        st_nxt.ports[i].count = RESUME_LOAD;
                        st_nxt.ports[i].resume_pulse = 1'b1; // [RL11]
                    end
                end
                PH_RESUMING: begin
                    if (st_r.ports[i].count == COUNT_ZERO) begin
                        st_nxt.ports[i].phase = PH_IDLE; // [RL8]
                        st_nxt.ports[i].suspend_chg = 1'b1; // [RL8]
                    end else begin
                        st_nxt.ports[i].count = st_r.ports[i].count - COUNT_ONE;
                    end
                end
                default: begin
                end
            endcase
            if (set_reset[i]) begin
                if (device_attached[i]) begin
                    // A repeated request restarts the full reset interval
                    st_nxt.ports[i].phase = PH_RESETTING; // [RL2]
                    st_nxt.ports[i].count = RESET_LOAD;
                end else begin
                    st_nxt.ports[i].connect_chg = 1'b1; // [RL3]
                end
            end else if (set_suspend[i]) begin
                if (!device_attached[i]) begin
                    st_nxt.ports[i].connect_chg = 1'b1; // [RL13]
                end else if (st_nxt.ports[i].phase == PH_IDLE) begin
                    st_nxt.ports[i].phase = PH_SUSPENDED; // [RL12] [RL8] [RL9]
                end
            end
            if (controller_resume_state && is_suspended(st_nxt.ports[i].phase)) begin
                st_nxt.ports[i].phase = PH_IDLE; // [RL10]
            end
            // Losing the device ends any signaling; no change flag of ours is raised
            if (!device_attached[i]) begin
                st_nxt.ports[i].phase = PH_IDLE; // [RL9]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '{ports: {NUM_PORTS{PORT_RESET_VALUE}}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_reset_active[i] = (st_r.ports[i].phase == PH_RESETTING);
            port_suspended[i] = st_r.ports[i].phase[1];
            resume_to_controller[i] = st_r.ports[i].resume_pulse; // [RL11]
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Each port is checked on its own state alone
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk // [RL16]
        a_reset_starts: assert property ( // [RL2]
            set_reset[g] && device_attached[g] && $past(device_attached[g])
            |=> port_reset_active[g] || !device_attached[g])
            else $error("Reset write did not start reset signaling");
        a_reset_detached: assert property ( // [RL3]
            set_reset[g] && !device_attached[g]
            |=> !port_reset_active[g] && status_word[g][BIT_CONNECT_CHG])
            else $error("Reset on detached port mishandled");
        a_reset_ends_chg: assert property ( // [RL14]
            $fell(port_reset_active[g]) && device_attached[g] && $past(device_attached[g])
            |-> status_word[g][BIT_RESET_CHG])
            else $error("Reset ended without reset change");
        a_oc_unsupported: assert property ( // [RL5]
            !per_port_oc_mode |=> !status_word[g][BIT_OVERCURRENT])
            else $error("Overcurrent bit set without per-port mode");
        a_oc_follows: assert property ( // [RL6]
            per_port_oc_mode && overcurrent_in[g] |=> status_word[g][BIT_OVERCURRENT])
            else $error("Overcurrent condition not reported");
        a_suspend_set: assert property ( // [RL12]
            set_suspend[g] && !set_reset[g] && device_attached[g] && !controller_resume_state
            && st_r.ports[g].phase == PH_IDLE ##1 device_attached[g] |-> port_suspended[g])
            else $error("Suspend write did not suspend port");
        a_suspend_detached: assert property ( // [RL9]
            !device_attached[g] |=> !port_suspended[g])
            else $error("Suspend status while detached");
        a_suspend_detach_chg: assert property ( // [RL13]
            set_suspend[g] && !device_attached[g] |=> status_word[g][BIT_CONNECT_CHG])
            else $error("Suspend on detached port set no connect change");
        a_ctrl_resume: assert property ( // [RL10]
            controller_resume_state |=> !port_suspended[g])
            else $error("Controller resume did not clear suspend");
        a_resume_end: assert property ( // [RL8]
            $rose(status_word[g][BIT_SUSPEND_CHG]) |-> !port_suspended[g])
            else $error("Suspend change set while still suspended");
        a_resume_prop: assert property ( // [RL11]
            st_r.ports[g].phase == PH_SUSPENDED && upstream_resume[g] && device_attached[g]
            && !controller_resume_state && !write_hit[g]
            |=> resume_to_controller[g] ##1 !resume_to_controller[g])
            else $error("Upstream resume not passed to controller");
        c_reset_done: cover property ($fell(port_reset_active[g]) && device_attached[g]);
        c_resume_done: cover property ($rose(status_word[g][BIT_SUSPEND_CHG]));
        c_detached_try: cover property (set_suspend[g] && !device_attached[g]);
        c_suspended: cover property ($rose(port_suspended[g]));
    end

endmodule

// file: pkg/rh_port_pkg.sv
// Shared constants and types for the root hub port status logic
package rh_port_pkg;

    // ----------------------------------------
    // Ports and register map
    // ----------------------------------------
    localparam int NUM_PORTS = 2;
    localparam logic [7:0] PORT_STATUS_BASE = 8'h54;
    localparam logic [7:0] PORT_STATUS_STRIDE = 8'h04;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // ----------------------------------------
    // Field positions in the port status word
    // ----------------------------------------
    localparam int BIT_ATTACHED = 0;
    localparam int BIT_SUSPEND = 2;
    localparam int BIT_OVERCURRENT = 3;
    localparam int BIT_RESET = 4;
    localparam int BIT_CONNECT_CHG = 16;
    localparam int BIT_SUSPEND_CHG = 18;
    localparam int BIT_RESET_CHG = 20;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_MHZ = 250;
    localparam int PORT_RESET_TIME_US = 10000;
    localparam int RESUME_TIME_US = 20000;
    localparam int PORT_RESET_CYCLES = PORT_RESET_TIME_US * CLOCK_MHZ;
    localparam int RESUME_CYCLES = RESUME_TIME_US * CLOCK_MHZ;
    localparam int COUNT_W = 32;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;

    // ----------------------------------------
    // Port phase and state
    // ----------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RESETTING = 2'b01,
        PH_SUSPENDED = 2'b10,
        PH_RESUMING = 2'b11
    } port_phase_e;

    typedef struct packed {
        port_phase_e phase;
        logic [COUNT_W-1:0] count;
        logic reset_chg;
        logic suspend_chg;
        logic connect_chg;
        logic oc_flag;
        logic resume_pulse;
    } port_s;

    typedef struct packed {
        port_s [NUM_PORTS-1:0] ports;
    } hub_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic rvalid;
    } regif_s;

    localparam port_s PORT_RESET_VALUE = '{
        phase: PH_IDLE,
        count: COUNT_ZERO,
        reset_chg: 1'b0,
        suspend_chg: 1'b0,
        connect_chg: 1'b0,
        oc_flag: 1'b0,
        resume_pulse: 1'b0
    };

    // Byte address of a port's status word
    function automatic logic [7:0] port_addr(input int idx);
        port_addr = PORT_STATUS_BASE + PORT_STATUS_STRIDE * idx[7:0];
    endfunction

endpackage

// file: core/port_reg_access.sv
// Register access decode and registered read data for the port status words
module port_reg_access
    import rh_port_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Port side
    input wire logic [NUM_PORTS-1:0][31:0] status_word,
    output logic [NUM_PORTS-1:0] write_hit
);

    regif_s st_r;
    regif_s st_nxt;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = reg_rd;
        st_nxt.rdata = READ_UNMAPPED;
        write_hit = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (reg_addr == port_addr(i)) begin
                write_hit[i] = reg_wr;
                if (reg_rd) begin
                    st_nxt.rdata = status_word[i];
                end
            end
        end
        if (!reg_rd) begin
            st_nxt.rdata = st_r.rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '{rdata: READ_UNMAPPED, rvalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;

    a_read_valid: assert property (@(posedge clock) disable iff (srst)
        reg_rd |=> reg_rvalid)
        else $error("Read strobe gave no read valid");

endmodule

// file: tb/usb_dev_model.sv
// Behavioural downstream device model for both root hub ports
module usb_dev_model
    import rh_port_pkg::*;
(
    // Clock
    input wire logic clock,
    // Bench commands
    input wire logic [NUM_PORTS-1:0] plug_cmd,
    input wire logic [NUM_PORTS-1:0] oc_cmd,
    input wire logic [NUM_PORTS-1:0] wake_cmd,
    // Port conditions
    output logic [NUM_PORTS-1:0] device_attached,
    output logic [NUM_PORTS-1:0] overcurrent_in,
    output logic [NUM_PORTS-1:0] upstream_resume
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Line levels
    // ----------------------------------------
    initial begin
        device_attached = '0;
        overcurrent_in = '0;
        upstream_resume = '0;
    end

    // Levels move on the edge so the design sees them one edge later
    always @(posedge clock) begin
        device_attached <= plug_cmd;
        overcurrent_in <= oc_cmd;
        // An absent device cannot signal resume
        upstream_resume <= wake_cmd & plug_cmd;
    end
endmodule

// file: tb/root_hub_port_status_tb.sv
// Self-checking testbench for the root hub port status block
module root_hub_port_status_tb
    import rh_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int RST_LEN = 20;
    localparam int RES_LEN = 30;
    localparam logic [7:0] A0 = 8'h54;
    localparam logic [7:0] A1 = 8'h58;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic [NUM_PORTS-1:0] device_attached, overcurrent_in, upstream_resume;
    logic [NUM_PORTS-1:0] port_reset_active, port_suspended, resume_to_controller;
    logic [NUM_PORTS-1:0] plug_cmd = '0;
    logic [NUM_PORTS-1:0] oc_cmd = '0;
    logic [NUM_PORTS-1:0] wake_cmd = '0;
    logic controller_resume_state = 1'b0;
    logic per_port_oc_mode = 1'b0;
    logic [15:0] lfsr = 16'h9a9b;
    int failures = 0;
    int tests_run = 0;
    int n;

    always #2 clock = ~clock;

    root_hub_port_status #(.RESET_CYCLES(RST_LEN), .RESUME_LEN_CYCLES(RES_LEN)) uut (
        .clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .device_attached(device_attached),
        .overcurrent_in(overcurrent_in), .upstream_resume(upstream_resume),
        .controller_resume_state(controller_resume_state),
        .per_port_oc_mode(per_port_oc_mode), .port_reset_active(port_reset_active),
        .port_suspended(port_suspended), .resume_to_controller(resume_to_controller));

    usb_dev_model dev (
        .clock(clock), .plug_cmd(plug_cmd), .oc_cmd(oc_cmd), .wake_cmd(wake_cmd),
        .device_attached(device_attached), .overcurrent_in(overcurrent_in),
        .upstream_resume(upstream_resume));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [31:0] st(input logic att, susp, oc, rst, cc, sc, rc);
        logic [31:0] w;
        w = 32'h0;
        w[BIT_ATTACHED] = att;
        w[BIT_SUSPEND] = susp;
        w[BIT_OVERCURRENT] = oc;
        w[BIT_RESET] = rst;
        w[BIT_CONNECT_CHG] = cc;
        w[BIT_SUSPEND_CHG] = sc;
        w[BIT_RESET_CHG] = rc;
        return w;
    endfunction

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tick();
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        tick();
        reg_rd = 1'b1;
        reg_addr = a;
        tick();
        reg_rd = 1'b0;
        chk("reg_rvalid", 32'h1, {31'h0, reg_rvalid});
        chk("reg_rdata", e, reg_rdata);
    endtask

    // Bounded wait for the end of reset signaling on one port
    task automatic wait_rst(input int p);
        n = 0;
        while (port_reset_active[p] === 1'b1 && n < 200) begin
            tick();
            n++;
        end
    endtask

    task automatic final_report();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run is about two hundred cycles; this cuts a hang
    initial begin
        #20000;
        failures++;
        final_report();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        #1 srst = 1'b0;
        rdchk(A0, st(0, 0, 0, 0, 0, 0, 0));
        rdchk(8'h50, READ_UNMAPPED);
        wr(8'h50, 32'hffff_ffff);
        wr(A0, 32'h10);
        wr(A1, 32'h4);
        chk("port_reset_active", 32'h0, {30'h0, port_reset_active});
        chk("port_suspended", 32'h0, {30'h0, port_suspended});
        rdchk(A0, st(0, 0, 0, 0, 1, 0, 0));
        rdchk(A1, st(0, 0, 0, 0, 1, 0, 0));
        wr(A0, 32'h1_0000);
        wr(A1, 32'h1_0000);
        plug_cmd = 2'b11;
        tick();
        wr(A0, 32'h0);
        rdchk(A0, st(1, 0, 0, 0, 0, 0, 0));
        // Reset length and completion
        wr(A0, 32'h10);
        chk("port_reset_active", 32'h1, {30'h0, port_reset_active});
        wait_rst(0);
        chk("reset length", 32'(RST_LEN), 32'(n));
        rdchk(A0, st(1, 0, 0, 0, 0, 0, 1));
        wr(A0, 32'h10_0000);
        // Suspend, upstream resume, end of resume interval
        wr(A1, 32'h4);
        chk("port_suspended", 32'h2, {30'h0, port_suspended});
        rdchk(A1, st(1, 1, 0, 0, 0, 0, 0));
        wake_cmd = 2'b10;
        tick();
        tick();
        chk("resume_to_controller", 32'h2, {30'h0, resume_to_controller});
        wake_cmd = 2'b00;
        tick();
        chk("resume_to_controller", 32'h0, {30'h0, resume_to_controller});
        chk("port_suspended", 32'h2, {30'h0, port_suspended});
        n = 0;
        while (port_suspended[1] === 1'b1 && n < 200) begin
            tick();
            n++;
        end
        chk("resume length", 32'h1, {31'h0, n >= RES_LEN - 3 && n <= RES_LEN + 3});
        rdchk(A1, st(1, 0, 0, 0, 0, 1, 0));
        wr(A1, 32'h4_0000);
        // Controller resume state clears suspend with no change flag
        wr(A0, 32'h4);
        controller_resume_state = 1'b1;
        tick();
        tick();
        chk("port_suspended", 32'h0, {30'h0, port_suspended});
        controller_resume_state = 1'b0;
        rdchk(A0, st(1, 0, 0, 0, 0, 0, 0));
        // A reset write clears suspend
        wr(A1, 32'h4);
        wr(A1, 32'h10);
        wait_rst(1);
        chk("port_suspended", 32'h0, {30'h0, port_suspended});
        rdchk(A1, st(1, 0, 0, 0, 0, 0, 1));
        wr(A1, 32'h10_0000);
        // Overcurrent, first without per-port mode, then at random
        for (int i = 0; i < 9; i++) begin
            lfsr = lfsr_next(lfsr);
            oc_cmd = (i == 0) ? 2'b11 : lfsr[1:0];
            per_port_oc_mode = (i == 0) ? 1'b0 : lfsr[2];
            tick();
            tick();
            rdchk(A0, st(1, 0, per_port_oc_mode & oc_cmd[0], 0, 0, 0, 0));
            rdchk(A1, st(1, 0, per_port_oc_mode & oc_cmd[1], 0, 0, 0, 0));
        end
        final_report();
    end
endmodule
